// >>> common/tsp_byte_if.sv
/*
  Valid/ready byte carrier between the port logic and its receive buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface tsp_byte_if import tsp_pkg::*; ();
  logic valid;
  logic ready;
  logic [RX_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// >>> common/tsp_pkg.sv
/*
  Shared constants, types and decoding for the two-wire command port slave.
  Assumes a single 100 MHz clock domain and a nonvolatile address field held
  elsewhere on the chip, loaded into the port after reset.
*/
// Behaviour
// R1: An active-low reset returns all port state to its initial condition, even while asleep.
// R2: With the sleep request low the port works; with it high the port ignores SDA and SCL.
// R3: For 50 ms after the sleep request falls the port honours no bus transition.
// R4: The port accepts commands 60 ms after reset release, later while a security delay holds.
// R5: The port is a pure slave and never holds SCL low.
// R6: Bit 0 of the address byte gives direction: one is slave to master, zero is master to slave.
// R7: Only command-path writes carry a command code byte, right after the address byte.
// R8: A size byte precedes operand or output bytes; status reads carry no size byte.
// R9: The upper six address bits are compared with the stored bus address; a mismatch is NACKed.
// R10: The stored bus address field starts at 0xC0 in a fresh part.
// R11: While busy, an address byte selecting the command path is NACKed.
// R12: The size should match the command's operand count; a mismatch is handled per command.
// R13: A master sharing the bus with a companion chip gives each chip its own address.
// R14: Address bit 1 at zero selects the command path, at one the single status byte read.
// R15: Status reads are accepted at any time, busy or in a penalty.
// R16: While asleep, starting up or otherwise unable, the port leaves SDA released (no ACK).
package tsp_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned WAKE_DELAY_MS = 50;
  localparam int unsigned STARTUP_DELAY_MS = 60;
  localparam int unsigned WAKE_CYCLES_DEF = WAKE_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_CYCLES_DEF = STARTUP_DELAY_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned DELAY_CNT_W = 23;

  // ************************************************************
  // Byte and address layout
  // ************************************************************
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned RX_W = BYTE_W + 1;
  localparam int unsigned RW_BIT = 0;
  localparam int unsigned SEL_BIT = 1;
  localparam int unsigned MATCH_LSB = 2;
  localparam logic RW_READ = 1'b1;
  localparam logic SEL_STATUS = 1'b1;
  localparam logic [7:0] DEV_ADDR_SHIPPED = 8'hC0;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ************************************************************
  // Types and decoding
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_DEC, ST_ADDR_ACK, ST_WR, ST_WR_DEC, ST_WR_ACK,
    ST_RD, ST_RD_ACK, ST_RD_MORE, ST_WAIT
  } tsp_state_t;

  // Upper six address bits against the stored field
  function automatic logic tsp_addr_hit(input logic [7:0] addr, input logic [7:0] field);
    return addr[BYTE_W-1:MATCH_LSB] == field[BYTE_W-1:MATCH_LSB];
  endfunction

endpackage

// >>> core/tsp_rx_buffer.sv
/*
  Two-entry receive buffer; entry 0 is always the head so outputs are flops.
  Assumes fill and drain share the clock of the port.
*/
`timescale 1ns/1ps
module tsp_rx_buffer import tsp_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  tsp_byte_if.dst fill,
  tsp_byte_if.src drain
);

  logic [RX_W-1:0] mem [0:1];
  logic [RX_W-1:0] next_mem [0:1];
  logic [1:0] full;
  logic [1:0] next_full;
  logic pop;
  logic push;

  // ************************************************************
  // Next entries: pop shifts down, push takes first free slot
  // ************************************************************
  always_comb begin
    next_mem = mem;
    next_full = full;
    pop = full[0] && drain.ready;
    push = fill.valid && !full[1];
    if (pop) begin
      next_mem[0] = mem[1];
      next_full = {1'b0, full[1]};
    end
    if (push) begin
      if (!next_full[0]) begin
        next_mem[0] = fill.data;
        next_full[0] = 1'b1;
      end else begin
        next_mem[1] = fill.data;
        next_full[1] = 1'b1;
      end
    end
  end

  // Entry registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      full <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        mem[i] <= '0;
      end
    end else begin
      full <= next_full;
      mem <= next_mem;
    end
  end

  assign fill.ready = !full[1];
  assign drain.valid = full[0];
  assign drain.data = mem[0];

endmodule

// >>> core/tsp_slave.sv
/*
  Two-wire slave command port: address decode, ACK/NACK, byte receive into
  a buffer, byte transmit from the command core or status, startup and sleep
  gating. Assumes pins arrive asynchronously and the core runs on clock.
*/
`timescale 1ns/1ps
module tsp_slave import tsp_pkg::*; #(
  parameter int unsigned WAKE_CYCLES = WAKE_CYCLES_DEF,
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep_request_input,
  input wire logic security_delay,
  input wire logic busy,
  input wire logic nv_addr_load,
  input wire logic [7:0] nv_addr_value,
  input wire logic [7:0] status_byte,
  input wire logic [7:0] tx_data,
  output logic tx_take,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_is_cmd,
  input wire logic rx_ready,
  output logic wr_stop,
  output logic port_ready
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic slp_m, slp_s;
  logic next_scl_d, next_sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [DELAY_CNT_W-1:0] delay_cnt, next_delay_cnt;
  logic next_port_ready;
  logic [7:0] dev_addr, next_dev_addr;
  tsp_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic rw, next_rw;
  logic sel, next_sel;
  logic first_byte, next_first_byte;
  logic in_write, next_in_write;
  logic next_sda_oe, next_tx_take, next_wr_stop;
  logic push_valid, next_push_valid;
  logic [RX_W-1:0] push_data, next_push_data;
  logic addr_ok;
  logic do_load;

  tsp_byte_if fill_if ();
  tsp_byte_if drain_if ();

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Two flops per pin; only the second stage is read by logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      slp_m <= 1'b0;
      slp_s <= 1'b0;
    end else begin
      scl_m <= scl_in; // R5
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      slp_m <= sleep_request_input;
      slp_s <= slp_m;
    end
  end

  // Previous synced levels for edge and condition detection
  always_comb begin
    next_scl_d = scl_s;
    next_sda_d = sda_s;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
    end
  end

  // Bus events; all ignored while sleeping
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ************************************************************
  // Startup, wake delay and stored address
  // ************************************************************
  // Counter reloads while asleep, counts down after wake or reset
  always_comb begin
    next_delay_cnt = delay_cnt;
    next_port_ready = port_ready;
    next_dev_addr = dev_addr;
    if (nv_addr_load) begin
      next_dev_addr = nv_addr_value;
    end
    if (slp_s) begin
      next_delay_cnt = DELAY_CNT_W'(WAKE_CYCLES); // R3
      next_port_ready = 1'b0; // R2
    end else if (delay_cnt != '0) begin
      next_delay_cnt = delay_cnt - DELAY_CNT_W'(1); // R3
    end else if (!security_delay) begin
      next_port_ready = 1'b1; // R4
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt <= DELAY_CNT_W'(STARTUP_CYCLES); // R1 R4
      port_ready <= 1'b0;
      dev_addr <= DEV_ADDR_SHIPPED; // R10
    end else begin
      delay_cnt <= next_delay_cnt;
      port_ready <= next_port_ready;
      dev_addr <= next_dev_addr;
    end
  end

  // ************************************************************
  // Address acceptance
  // ************************************************************
  // Status reads always; command path only when idle
  always_comb begin
    addr_ok = 1'b0;
    if (tsp_addr_hit(shreg, dev_addr)) begin // R9
      if (shreg[SEL_BIT] == SEL_STATUS) begin // R14
        addr_ok = (shreg[RW_BIT] == RW_READ); // R15 R8
      end else begin
        addr_ok = !busy; // R11
      end
    end
  end

  // ************************************************************
  // Bus state machine
  // ************************************************************
  // SCL is input only; the port never stretches the clock
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_rw = rw;
    next_sel = sel;
    next_first_byte = first_byte;
    next_in_write = in_write;
    next_sda_oe = sda_oe;
    next_tx_take = 1'b0;
    next_wr_stop = 1'b0;
    next_push_valid = 1'b0;
    next_push_data = push_data;
    do_load = 1'b0;
    if (slp_s || !port_ready) begin
      next_state = ST_IDLE; // R2 R16
      next_sda_oe = 1'b0; // R16
      next_in_write = 1'b0;
    end else if (bus_stop) begin
      next_state = ST_IDLE;
      next_sda_oe = 1'b0;
      next_wr_stop = in_write;
      next_in_write = 1'b0;
    end else if (bus_start) begin
      next_state = ST_ADDR;
      next_bit_cnt = 3'h0;
      next_sda_oe = 1'b0;
      next_wr_stop = in_write;
      next_in_write = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE, ST_WAIT: begin
          next_sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_shreg = {shreg[BYTE_W-2:0], sda_s};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              next_state = ST_ADDR_DEC;
            end
          end
        end
        ST_ADDR_DEC: begin
          if (scl_fall) begin
            next_rw = shreg[RW_BIT]; // R6
            next_sel = shreg[SEL_BIT]; // R14
            if (addr_ok) begin
              next_sda_oe = 1'b1;
              next_state = ST_ADDR_ACK;
            end else begin
              next_state = ST_WAIT; // R9 R11
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw == RW_READ) begin // R6
              do_load = 1'b1;
            end else begin
              next_sda_oe = 1'b0;
              next_state = ST_WR;
              next_bit_cnt = 3'h0;
              next_first_byte = 1'b1; // R7
              next_in_write = 1'b1;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            next_shreg = {shreg[BYTE_W-2:0], sda_s};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              next_state = ST_WR_DEC;
            end
          end
        end
        ST_WR_DEC: begin
          if (scl_fall) begin
            // A full buffer refuses the byte with a NACK
            if (fill_if.ready) begin
              next_push_valid = 1'b1;
              next_push_data = {first_byte, shreg}; // R7 R8 R12
              next_first_byte = 1'b0;
              next_sda_oe = 1'b1;
              next_state = ST_WR_ACK;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_bit_cnt = 3'h0;
            next_state = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == LAST_BIT) begin
              next_sda_oe = 1'b0;
              next_state = ST_RD_ACK;
            end else begin
              next_shreg = {shreg[BYTE_W-2:0], 1'b0};
              next_sda_oe = !shreg[BYTE_W-2];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_state = sda_s ? ST_WAIT : ST_RD_MORE;
          end
        end
        ST_RD_MORE: begin
          if (scl_fall) begin
            do_load = 1'b1;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
      // Load next outgoing byte and drive its first bit
      if (do_load) begin
        if (sel == SEL_STATUS) begin
          next_shreg = status_byte; // R8 R15
        end else begin
          next_shreg = tx_data; // R8
          next_tx_take = 1'b1;
        end
        next_sda_oe = (sel == SEL_STATUS) ? !status_byte[BYTE_W-1] : !tx_data[BYTE_W-1];
        next_bit_cnt = 3'h0;
        next_state = ST_RD;
      end
    end
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE; // R1
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      sel <= 1'b0;
      first_byte <= 1'b0;
      in_write <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      tx_take <= 1'b0;
      wr_stop <= 1'b0;
      push_valid <= 1'b0;
      push_data <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      rw <= next_rw;
      sel <= next_sel;
      first_byte <= next_first_byte;
      in_write <= next_in_write;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0; // Open drain: only ever pulls low
      tx_take <= next_tx_take;
      wr_stop <= next_wr_stop;
      push_valid <= next_push_valid;
      push_data <= next_push_data;
    end
  end

  // ************************************************************
  // Receive buffer
  // ************************************************************
  assign fill_if.valid = push_valid;
  assign fill_if.data = push_data;
  assign drain_if.ready = rx_ready;

  tsp_rx_buffer tsp_rx_buffer_i (
    .clock (clock),
    .rst_n (rst_n),
    .fill (fill_if.dst),
    .drain (drain_if.src)
  );

  // Buffer head flops straight to ports
  assign rx_valid = drain_if.valid;
  assign rx_data = drain_if.data[BYTE_W-1:0];
  assign rx_is_cmd = drain_if.data[BYTE_W];

endmodule

// >>> dv/test_twi_slave_command_port.sv
/*
  Testbench for the command port slave with a master model and a core model.
  Assumes shortened wake and startup counts given below.
*/
`timescale 1ns/1ps
module test_twi_slave_command_port import tsp_pkg::*;;
  localparam int WAKE = 300;
  localparam int STARTUP = 400;
  logic clock, rst_n, scl_in, sda_in, sda_out, sda_oe, sda_low, sleep_request_input;
  logic security_delay, busy, nv_addr_load, tx_take, rx_valid, rx_is_cmd, rx_ready;
  logic wr_stop, port_ready, hold_rx, ack;
  logic [7:0] nv_addr_value, status_byte, tx_data, rx_data, d, a;
  logic [31:0] r;
  logic [15:0] quiet;
  logic [8:0] rx_q[$];
  logic [7:0] tx_q[$];
  int errors, comparisons, stops, cycles, i;
  integer seed = 32'h9D61A403;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  tsp_slave #(.WAKE_CYCLES(WAKE), .STARTUP_CYCLES(STARTUP)) tsp_slave_i (.clock, .rst_n,
    .scl_in, .sda_in, .sda_out, .sda_oe, .sleep_request_input, .security_delay, .busy,
    .nv_addr_load, .nv_addr_value, .status_byte, .tx_data, .tx_take, .rx_valid, .rx_data,
    .rx_is_cmd, .rx_ready, .wr_stop, .port_ready);
  tsp_master_model tsp_master_model_i (.clock, .sda_line(sda_in), .scl(scl_in), .sda_low);
  // Open-drain data line with pull-up
  assign sda_in = !(sda_low || (sda_oe && !sda_out));
  task automatic compare(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic send_addr(input logic [7:0] b, input logic exp);
    tsp_master_model_i.start();
    tsp_master_model_i.wr_byte(b, ack);
    compare("address ack", {8'h00, exp}, {8'h00, ack});
  endtask
  task automatic put(input logic [7:0] b, input logic first, input logic exp);
    if (exp) begin
      rx_q.push_back({first, b});
    end
    tsp_master_model_i.wr_byte(b, ack);
    compare("byte ack", {8'h00, exp}, {8'h00, ack});
  endtask
  task automatic get(input logic [7:0] exp, input logic more);
    tsp_master_model_i.rd_byte(more, d);
    compare("read byte", {1'b0, exp}, {1'b0, d});
  endtask
  task automatic wait_ready(input int lo, input int hi);
    for (i = 0; i < 1000 && port_ready !== 1'b1; i++) begin
      @(negedge clock);
    end
    compare("ready", 9'h001, {8'h00, port_ready});
    compare("ready delay", 9'h001, {8'h00, quiet >= lo && quiet <= hi});
    repeat (4) @(negedge clock);
  endtask
  // Core side: random acceptance, output bytes on each take
  always @(negedge clock) begin
    r = $random(seed);
    rx_ready <= r[0] && !hold_rx;
    if (tx_take === 1'b1 && tx_q.size() > 0) begin
      tx_data <= tx_q.pop_front();
    end
  end
  // Received bytes, frame ends, gap to readiness, time limit
  always @(posedge clock) begin
    cycles++;
    if (rst_n && rx_valid && rx_ready) begin
      compare("rx byte", (rx_q.size() > 0) ? rx_q.pop_front() : 9'h1FF,
        {rx_is_cmd, rx_data});
    end
    if (wr_stop === 1'b1) stops++;
    if (!rst_n || sleep_request_input) quiet <= 16'h0000;
    else if (port_ready !== 1'b1) quiet <= quiet + 16'h0001;
    if (cycles == 95000) begin
      errors++;
      results();
    end
  end
  // Main sequence
  initial begin
    {rst_n, sleep_request_input, security_delay, busy, nv_addr_load, hold_rx} = 6'h00;
    {nv_addr_value, status_byte, tx_data} = 24'h000000;
    rx_ready = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    wait_ready(STARTUP, STARTUP + 8);
    for (int n = 0; n < 2; n++) begin
      a = 8'($random(seed));
      if (a[7:2] == 6'h30) a[7] = 1'b0;
      send_addr(a, 1'b0);
      tsp_master_model_i.stop();
    end
    $display("startup and address test done");
    a = {4'h0, 4'($random(seed))} + 8'h01;
    d = 8'($random(seed));
    send_addr(8'hC0, 1'b1);
    put(a, 1'b1, 1'b1);
    put(8'h02, 1'b0, 1'b1);
    put(d, 1'b0, 1'b1);
    put(~d, 1'b0, 1'b1);
    tsp_master_model_i.stop();
    repeat (10) @(negedge clock);
    compare("write frames", 9'h001, stops[8:0]);
    $display("command write test done");
    busy = 1'b1;
    status_byte = 8'($random(seed));
    send_addr(8'hC3, 1'b1);
    get(status_byte, 1'b1);
    get(status_byte, 1'b0);
    tsp_master_model_i.stop();
    send_addr(8'hC0, 1'b0);
    tsp_master_model_i.stop();
    send_addr(8'hC2, 1'b0);
    tsp_master_model_i.stop();
    busy = 1'b0;
    $display("status and busy test done");
    a = 8'($random(seed));
    tx_data = 8'h02;
    tx_q = '{a, ~a};
    send_addr(8'hC1, 1'b1);
    get(8'h02, 1'b1);
    get(a, 1'b1);
    get(~a, 1'b0);
    tsp_master_model_i.stop();
    $display("command read test done");
    hold_rx = 1'b1;
    send_addr(8'hC0, 1'b1);
    put(8'h0A, 1'b1, 1'b1);
    put(8'h5C, 1'b0, 1'b1);
    put(8'h33, 1'b0, 1'b0);
    tsp_master_model_i.stop();
    hold_rx = 1'b0;
    repeat (20) @(negedge clock);
    compare("bytes left", 9'h000, 9'(rx_q.size()));
    $display("buffer test done");
    nv_addr_value = 8'h54;
    nv_addr_load = 1'b1;
    @(negedge clock);
    nv_addr_load = 1'b0;
    send_addr(8'h57, 1'b1);
    get(status_byte, 1'b0);
    tsp_master_model_i.stop();
    send_addr(8'hC3, 1'b0);
    tsp_master_model_i.stop();
    sleep_request_input = 1'b1;
    repeat (10) @(negedge clock);
    compare("asleep", 9'h000, {8'h00, port_ready});
    send_addr(8'h57, 1'b0);
    tsp_master_model_i.stop();
    sleep_request_input = 1'b0;
    send_addr(8'h57, 1'b0);
    tsp_master_model_i.stop();
    wait_ready(WAKE, WAKE + 8);
    send_addr(8'h57, 1'b1);
    get(status_byte, 1'b0);
    tsp_master_model_i.stop();
    $display("address load and sleep test done");
    security_delay = 1'b1;
    rst_n = 1'b0;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (STARTUP + 60) @(negedge clock);
    compare("held off", 9'h000, {8'h00, port_ready});
    security_delay = 1'b0;
    wait_ready(STARTUP + 60, STARTUP + 68);
    send_addr(8'hC3, 1'b1);
    get(status_byte, 1'b0);
    tsp_master_model_i.stop();
    $display("reset and delay test done");
    results();
  end
endmodule

// >>> dv/tsp_master_model.sv
/*
  Bus master model: drives the clock line and pulls data low, at most 400 kHz.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/1ps
module tsp_master_model import tsp_pkg::*; (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  localparam int Q = 63; // Quarter bit, clock low is two of them
  localparam int H = 125; // Clock high time
  // Idle bus
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait falling clock edges
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask
  // One bit slot; a released line reads the slave
  task automatic slot(input logic b, output logic seen);
    sda_low = !b;
    w(Q);
    scl = 1'b1;
    w(H / 2);
    seen = sda_line;
    w(H - H / 2);
    scl = 1'b0;
    w(Q);
  endtask
  task automatic start();
    sda_low = 1'b1;
    w(Q);
    scl = 1'b0;
    w(Q);
  endtask
  task automatic stop();
    sda_low = 1'b1;
    w(Q);
    scl = 1'b1;
    w(Q);
    sda_low = 1'b0;
    w(H);
  endtask
  // Address byte first in each frame, bit 0 gives direction
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int k = 7; k >= 0; k--) begin
      slot(b[k], seen);
    end
    slot(1'b1, seen);
    ack = !seen;
  endtask
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic seen;
    for (int k = 7; k >= 0; k--) begin
      slot(1'b1, seen);
      b[k] = seen;
    end
    slot(!more, seen);
  endtask
endmodule

// >>> dv/tsp_slave_chk.sv
/*
  Checker for the command port slave: readiness timing, silence and pulses.
  Assumes a bind into tsp_slave, one clock and an async active-low reset.
*/
`timescale 1ns/1ps
module tsp_slave_chk import tsp_pkg::*; #(
  parameter int unsigned WAKE_CYCLES = 20,
  parameter int unsigned STARTUP_CYCLES = 30
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic sleep_request_input,
  input wire logic security_delay,
  input wire logic tx_take,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_is_cmd,
  input wire logic rx_ready,
  input wire logic wr_stop,
  input wire logic port_ready
);
  // ************************************************************
  // Cycles since reset release or wake
  // ************************************************************
  logic [15:0] quiet;
  logic [15:0] next_quiet;
  always_comb begin
    next_quiet = quiet;
    if (sleep_request_input) begin
      next_quiet = 16'h0000;
    end else if (quiet != 16'hFFFF) begin
      next_quiet = quiet + 16'h0001;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= 16'h0000;
    end else begin
      quiet <= next_quiet;
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_asleep;
    sleep_request_input [*6];
  endsequence
  sequence s_stalled;
    rx_valid && !rx_ready;
  endsequence
  a_reset_idle: assert property ($rose(rst_n) |->
    !sda_oe && !port_ready && !rx_valid && !tx_take && !wr_stop)
    else $error("outputs not idle after reset");
  a_ready_early: assert property ($rose(port_ready) |-> quiet >= WAKE_CYCLES)
    else $error("port ready too early");
  a_ready_late: assert property (quiet == STARTUP_CYCLES + 6 && !security_delay |->
    port_ready) else $error("port not ready after startup");
  a_sleep_silent: assert property (s_asleep |-> !port_ready && !sda_oe)
    else $error("port active while asleep");
  a_unready_silent: assert property (!port_ready [*2] |-> !sda_oe && !tx_take)
    else $error("port active while not ready");
  a_rx_held: assert property (s_stalled |=>
    rx_valid && $stable(rx_data) && $stable(rx_is_cmd))
    else $error("stalled byte lost or changed");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_take_pulse: assert property (tx_take |-> !scl_in ##1 !tx_take)
    else $error("byte take not a single pulse");
  a_stop_pulse: assert property (wr_stop |=> !wr_stop)
    else $error("frame end not a single pulse");
endmodule
bind tsp_slave tsp_slave_chk #(.WAKE_CYCLES(WAKE_CYCLES), .STARTUP_CYCLES(STARTUP_CYCLES))
  tsp_slave_chk_i (.clock, .rst_n, .scl_in, .sda_oe, .sleep_request_input, .security_delay,
  .tx_take, .rx_valid, .rx_data, .rx_is_cmd, .rx_ready, .wr_stop, .port_ready);
